// ---- include/soa_consts.svh ----
// Constants of the servo output arbiter: map, fields, resets and timing.
// How it works
// - Source priority: manual, wiper, reset, preset, error, PID.
// - Hand override enters while running or in reset.
// - Hand override drives motor from keys, not demand.
// - Up key opens, down key closes in override.
// - With feedback, inputs pick one of seven presets.
// - With feedback, preset to PID is bumpless inside band.
// - Without feedback: P2 close, P3 open, others stop.
// - Without feedback, preset to PID jumps directly.
// - All preset inputs off selects PID demand, or error action if set.
// - Limiter never applies to override or presets.
// - PID demand clamped only when feedback fitted.
// - Demand is target; motor moves respecting dead zone.
// - Low wire open reads zero; Open held.
// - Wiper open flags fault; with feedback, drives configured action.
// - High wire open reads full; Close held.
// - No feedback at 0/100% pulses 5% stroke per 30s.
// - Hysteresis is a quarter of the dead zone from 1.2% up.
// - Hysteresis 0.3% below 1.2%, 0.2% at 0.2%.
// - Override disables preset, keys still work.
// - Leaving override resumes the selected preset.
// - Dead zone 0.2 to 10.0%, default 2.0%.
`ifndef SOA_CONSTS_SVH
`define SOA_CONSTS_SVH
`define SOA_ADR_CTRL 8'h00
`define SOA_ADR_DEMAND 8'h04
`define SOA_ADR_DEADZ 8'h08
`define SOA_ADR_LIMIT 8'h0C
`define SOA_ADR_PBAND 8'h10
`define SOA_ADR_STROKE 8'h14
`define SOA_ADR_STATUS 8'h18
`define SOA_ADR_POSN 8'h1C
`define SOA_ADR_PRE_FIRST 8'h20
`define SOA_ADR_PRE_LAST 8'h38
`define SOA_FULL 10'h3E8
`define SOA_DZ_MIN 7'h02
`define SOA_DZ_MAX 7'h64
`define SOA_DZ_RST 7'h14
`define SOA_DZ_FIX 7'h0C
`define SOA_HYST_FIX 7'h03
`define SOA_HYST_MIN 7'h02
`define SOA_PB_RST 10'h032
`define SOA_STROKE_RST 8'h1E
`define SOA_CLK_HZ 20000000
`define SOA_PULSE_PERIOD_S 30
`define SOA_PULSE_PCT 5
`define SOA_BUMP_STEP_MS 1
`define SOA_PERIOD_CYC (`SOA_PULSE_PERIOD_S * `SOA_CLK_HZ)
`define SOA_PULSE_UNIT_CYC (`SOA_CLK_HZ / 100 * `SOA_PULSE_PCT)
`define SOA_EST_UNIT_CYC (`SOA_CLK_HZ / 1000)
`define SOA_BUMP_CYC (`SOA_CLK_HZ / 1000 * `SOA_BUMP_STEP_MS)
`endif

// ---- include/soa_pkg.sv ----
// Types shared by the servo output arbiter modules.
package soa_pkg;
   typedef enum logic [2:0] {
      SRC_MANUAL = 3'h0,
      SRC_WIPER = 3'h1,
      SRC_RESET = 3'h3,
      SRC_PRESET = 3'h2,
      SRC_ERROR = 3'h6,
      SRC_PID = 3'h7
   } soa_src_t;
   typedef enum logic [1:0] {
      ACT_STOP = 2'h0,
      ACT_CLOSE = 2'h1,
      ACT_OPEN = 2'h2,
      ACT_IDLE = 2'h3
   } soa_act_t;
   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic ovr;
      logic fb;
      logic stby;
      logic ierr;
      soa_act_t wact;
      soa_act_t ract;
      soa_act_t eact;
      logic [9:0] demand;
      logic [6:0] dz;
      logic [9:0] lim_lo;
      logic [9:0] lim_hi;
      logic [9:0] pb;
      logic [7:0] stroke;
      logic [6:0][9:0] preset;
      logic [9:0] tgt;
      logic bump;
      logic [31:0] bcnt;
      logic [9:0] est;
      logic [31:0] tick;
      logic open;
      logic close;
      soa_src_t src;
   } soa_top_t;
   typedef struct packed {
      logic [31:0] cnt;
      logic pulse;
   } soa_pulse_t;
endpackage

// ---- design/soa_sync3.sv ----
// Three-stage pin synchroniser that accepts a change once stages agree.
`timescale 1ns/1ps
module soa_sync3 #(
   parameter int W = 6
)
(
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] val;
   } soa_sync_t;
   soa_sync_t q;
   soa_sync_t d;
   always_comb
   begin
      d = q;
      d.s1 = d_in;
      d.s2 = q.s1;
      d.s3 = q.s2;
      for (int i = 0; i < W; i++)
      begin
         if (q.s2[i] == q.s3[i])
         begin
            d.val[i] = q.s3[i];
         end
      end
      if (srst_in)
      begin
         d = '0;
      end
   end
   always_ff @(posedge clk_in)
   begin
      q <= d;
   end
   assign q_out = q.val;
endmodule

// ---- design/soa_pulse_timer.sv ----
// Periodic end-position pulse generator for the no-feedback case.
`timescale 1ns/1ps
`include "soa_consts.svh"
module soa_pulse_timer
   import soa_pkg::*;
#(
   parameter int unsigned PERIOD_CYC = `SOA_PERIOD_CYC
)
(
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic en_in,
   input wire logic [31:0] len_in,
   output logic pulse_out
);
   soa_pulse_t q;
   soa_pulse_t d;
   // The period restarts whenever the enable drops, so each new hold
   // at an end position begins with a full pulse.
   always_comb
   begin
      d = q;
      if (!en_in || q.cnt >= PERIOD_CYC - 1)
      begin
         d.cnt = '0;
      end
      else
      begin
         d.cnt = q.cnt + 32'h1;
      end
      // The old count is compared so that the first pulse after the enable
      // is as long as every later one.
      d.pulse = en_in && (q.cnt < len_in);
      if (srst_in)
      begin
         d = '0;
      end
   end
   always_ff @(posedge clk_in)
   begin
      q <= d;
   end
   assign pulse_out = q.pulse;
endmodule

// ---- design/soa_servo_top.sv ----
// Servo output arbiter: source priority, servo band and Wishbone registers.
//
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "soa_consts.svh"
module soa_servo_top
   import soa_pkg::*;
#(
   parameter int unsigned PERIOD_CYC = `SOA_PERIOD_CYC,
   parameter int unsigned PULSE_UNIT_CYC = `SOA_PULSE_UNIT_CYC,
   parameter int unsigned EST_UNIT_CYC = `SOA_EST_UNIT_CYC,
   parameter int unsigned BUMP_CYC = `SOA_BUMP_CYC
)
(
   input wire logic SYS_CLK_IN,
   input wire logic SRST_IN,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_WE_IN,
   input wire logic [7:0] WB_ADR_IN,
   input wire logic [3:0] WB_SEL_IN,
   input wire logic [31:0] WB_DAT_IN,
   output logic [31:0] WB_DAT_OUT,
   output logic WB_ACK_OUT,
   input wire logic KEY_UP_IN,
   input wire logic KEY_DOWN_IN,
   input wire logic [2:0] PRESET_SEL_IN,
   input wire logic WIPER_OPEN_IN,
   input wire logic [11:0] POS_IN,
   output logic MOTOR_OPEN_OUT,
   output logic MOTOR_CLOSE_OUT
);
   soa_top_t q;
   soa_top_t d;
   logic [5:0] pins_f;
   logic key_up;
   logic key_dn;
   logic wiper_f;
   logic [2:0] psel;
   logic [2:0] pidx;
   logic [2:0] widx;
   logic pulse;
   logic pulse_en;
   logic [31:0] pulse_len;
   logic [31:0] est_lim;
   logic [31:0] rd_word;
   logic [31:0] wmask;
   logic [31:0] wdat;
   logic wr;
   logic [9:0] dl;
   logic [9:0] tgt_eff;
   logic [9:0] preset_v;
   logic [9:0] gap;
   logic [6:0] hyst;
   logic signed [12:0] posv;
   logic signed [12:0] pos_s;
   logic signed [12:0] lo_th;
   logic signed [12:0] hi_th;
   logic srv_open;
   logic srv_close;

   soa_sync3 #(
      .W(6)
   ) u_sync (
      .clk_in(SYS_CLK_IN),
      .srst_in(SRST_IN),
      .d_in({KEY_UP_IN, KEY_DOWN_IN, WIPER_OPEN_IN, PRESET_SEL_IN}),
      .q_out(pins_f)
   );
   assign {key_up, key_dn, wiper_f, psel} = pins_f;

   soa_pulse_timer #(
      .PERIOD_CYC(PERIOD_CYC)
   ) u_pulse (
      .clk_in(SYS_CLK_IN),
      .srst_in(SRST_IN),
      .en_in(pulse_en),
      .len_in(pulse_len),
      .pulse_out(pulse)
   );

   // Returns {open, close} for a configured fixed action.
   function automatic logic [1:0] act_drive(input soa_act_t a);
      case (a)
         ACT_OPEN: act_drive = 2'h2;
         ACT_CLOSE: act_drive = 2'h1;
         default: act_drive = 2'h0;
      endcase
   endfunction

   always_comb
   begin
      d = q;
      wr = WB_CYC_IN && WB_STB_IN && !q.ack;
      pidx = (psel == 3'h0) ? 3'h0 : psel - 3'h1;
      widx = 3'((WB_ADR_IN - `SOA_ADR_PRE_FIRST) >> 2);
      pulse_len = 32'(q.stroke) * PULSE_UNIT_CYC;
      est_lim = 32'(q.stroke) * EST_UNIT_CYC;
      pos_s = {POS_IN[11], POS_IN};
      preset_v = q.preset[pidx];
      if (q.dz == `SOA_DZ_MIN)
      begin
         hyst = `SOA_HYST_MIN;
      end
      else if (q.dz < `SOA_DZ_FIX)
      begin
         hyst = `SOA_HYST_FIX;
      end
      else
      begin
         hyst = q.dz >> 2;
      end
      dl = q.demand;
      if (q.fb)
      begin
         if (dl < q.lim_lo)
         begin
            dl = q.lim_lo;
         end
         else if (dl > q.lim_hi)
         begin
            dl = q.lim_hi;
         end
      end
      // Override is checked before standby, so it is taken in either.
      if (q.ovr)
      begin
         d.src = SRC_MANUAL;
      end
      else if (q.fb && wiper_f)
      begin
         d.src = SRC_WIPER;
      end
      else if (q.stby)
      begin
         d.src = SRC_RESET;
      end
      else if (psel != 3'h0)
      begin
         d.src = SRC_PRESET;
      end
      else if (q.ierr)
      begin
         d.src = SRC_ERROR;
      end
      else
      begin
         d.src = SRC_PID;
      end
      gap = (dl > q.tgt) ? dl - q.tgt : q.tgt - dl;
      if (d.src == SRC_PRESET)
      begin
         d.tgt = preset_v;
         d.bump = 1'b0;
      end
      else if (q.src == SRC_PRESET && d.src == SRC_PID)
      begin
         d.bump = q.fb && (gap <= q.pb);
         d.bcnt = '0;
      end
      else if (q.bump && d.src == SRC_PID)
      begin
         // Slew one step per interval so the valve walks to the demand.
         if (q.bcnt >= BUMP_CYC - 1)
         begin
            d.bcnt = '0;
            if (q.tgt < dl)
            begin
               d.tgt = q.tgt + 10'h001;
            end
            else if (q.tgt > dl)
            begin
               d.tgt = q.tgt - 10'h001;
            end
            else
            begin
               d.bump = 1'b0;
            end
         end
         else
         begin
            d.bcnt = q.bcnt + 32'h1;
         end
      end
      else
      begin
         d.bump = 1'b0;
      end
      if (d.src == SRC_PRESET)
      begin
         tgt_eff = preset_v;
      end
      else
      begin
         tgt_eff = d.bump ? q.tgt : dl;
      end
      posv = q.fb ? pos_s : $signed({3'h0, q.est});
      lo_th = $signed({3'h0, tgt_eff}) - $signed({6'h0, q.dz >> 1});
      hi_th = $signed({3'h0, tgt_eff}) + $signed({6'h0, q.dz >> 1});
      if (q.open)
      begin
         srv_open = posv < lo_th + $signed({6'h0, hyst});
      end
      else
      begin
         srv_open = posv < lo_th;
      end
      if (q.close)
      begin
         srv_close = !srv_open && (posv > hi_th - $signed({6'h0, hyst}));
      end
      else
      begin
         srv_close = !srv_open && (posv > hi_th);
      end
      pulse_en = !q.fb && d.src == SRC_PID
         && ((dl == 10'h000 && q.est == 10'h000)
         || (dl == `SOA_FULL && q.est == `SOA_FULL));
      case (d.src)
         SRC_MANUAL:
         begin
            d.open = key_up && !key_dn;
            d.close = key_dn && !key_up;
         end
         SRC_WIPER: {d.open, d.close} = act_drive(q.wact);
         SRC_RESET: {d.open, d.close} = act_drive(q.ract);
         SRC_ERROR: {d.open, d.close} = act_drive(q.eact);
         SRC_PRESET:
         begin
            if (q.fb)
            begin
               {d.open, d.close} = {srv_open, srv_close};
            end
            else
            begin
               d.open = (psel == 3'h3);
               d.close = (psel == 3'h2);
            end
         end
         default:
         begin
            {d.open, d.close} = {srv_open, srv_close};
            if (pulse_en)
            begin
               d.open = (dl == `SOA_FULL) && pulse;
               d.close = (dl == 10'h000) && pulse;
            end
            // The dead zone would park the estimate short of the end, so
            // the motor is run on until the estimate reaches the stop.
            else if (!q.fb && dl == `SOA_FULL)
            begin
               d.open = 1'b1;
               d.close = 1'b0;
            end
            else if (!q.fb && dl == 10'h000)
            begin
               d.open = 1'b0;
               d.close = 1'b1;
            end
         end
      endcase
      if (q.fb && (d.src == SRC_PRESET || d.src == SRC_PID))
      begin
         if (pos_s <= 13'sh0)
         begin
            d.open = 1'b1;
            d.close = 1'b0;
         end
         else if (pos_s >= $signed({3'h0, `SOA_FULL}))
         begin
            d.open = 1'b0;
            d.close = 1'b1;
         end
      end
      // Without a potentiometer the position is inferred from run time.
      if (!q.fb && (q.open ^ q.close))
      begin
         if (q.tick >= est_lim - 32'h1)
         begin
            d.tick = '0;
            if (q.open && q.est < `SOA_FULL)
            begin
               d.est = q.est + 10'h001;
            end
            else if (q.close && q.est != 10'h000)
            begin
               d.est = q.est - 10'h001;
            end
         end
         else
         begin
            d.tick = q.tick + 32'h1;
         end
      end
      else
      begin
         d.tick = '0;
      end
      case (WB_ADR_IN)
         `SOA_ADR_CTRL: rd_word = {22'h0, q.eact, q.ract, q.wact,
            q.ierr, q.stby, q.fb, q.ovr};
         `SOA_ADR_DEMAND: rd_word = {22'h0, q.demand};
         `SOA_ADR_DEADZ: rd_word = {25'h0, q.dz};
         `SOA_ADR_LIMIT: rd_word = {6'h0, q.lim_hi, 6'h0, q.lim_lo};
         `SOA_ADR_PBAND: rd_word = {22'h0, q.pb};
         `SOA_ADR_STROKE: rd_word = {24'h0, q.stroke};
         `SOA_ADR_STATUS: rd_word = {9'h0, hyst, 9'h0, q.bump, wiper_f,
            q.src, q.close, q.open};
         `SOA_ADR_POSN: rd_word = {{19{posv[12]}}, posv};
         default: rd_word = 32'h0;
      endcase
      if (WB_ADR_IN >= `SOA_ADR_PRE_FIRST && WB_ADR_IN <= `SOA_ADR_PRE_LAST
         && WB_ADR_IN[1:0] == 2'h0)
      begin
         rd_word = {22'h0, q.preset[widx]};
      end
      wmask = {{8{WB_SEL_IN[3]}}, {8{WB_SEL_IN[2]}},
         {8{WB_SEL_IN[1]}}, {8{WB_SEL_IN[0]}}};
      wdat = (rd_word & ~wmask) | (WB_DAT_IN & wmask);
      d.ack = wr;
      if (wr)
      begin
         d.rdat = rd_word;
      end
      if (wr && WB_WE_IN)
      begin
         case (WB_ADR_IN)
            `SOA_ADR_CTRL:
            begin
               {d.ovr, d.fb, d.stby, d.ierr} = {wdat[0], wdat[1],
                  wdat[2], wdat[3]};
               d.wact = soa_act_t'(wdat[5:4]);
               d.ract = soa_act_t'(wdat[7:6]);
               d.eact = soa_act_t'(wdat[9:8]);
            end
            `SOA_ADR_DEMAND:
               d.demand = (wdat[9:0] > `SOA_FULL) ? `SOA_FULL : wdat[9:0];
            `SOA_ADR_DEADZ:
            begin
               if (wdat[6:0] >= `SOA_DZ_MIN && wdat[6:0] <= `SOA_DZ_MAX
                  && wdat[31:7] == 25'h0)
               begin
                  d.dz = wdat[6:0];
               end
            end
            `SOA_ADR_LIMIT:
            begin
               d.lim_lo = wdat[9:0];
               d.lim_hi = wdat[25:16];
            end
            `SOA_ADR_PBAND: d.pb = wdat[9:0];
            `SOA_ADR_STROKE:
            begin
               if (wdat[7:0] != 8'h00)
               begin
                  d.stroke = wdat[7:0];
               end
            end
            default:
            begin
               if (WB_ADR_IN >= `SOA_ADR_PRE_FIRST
                  && WB_ADR_IN <= `SOA_ADR_PRE_LAST
                  && WB_ADR_IN[1:0] == 2'h0)
               begin
                  d.preset[widx] = wdat[9:0];
               end
            end
         endcase
      end
      if (SRST_IN)
      begin
         d = '0;
         d.dz = `SOA_DZ_RST;
         d.lim_hi = `SOA_FULL;
         d.pb = `SOA_PB_RST;
         d.stroke = `SOA_STROKE_RST;
         d.src = SRC_PID;
      end
   end

   always_ff @(posedge SYS_CLK_IN)
   begin
      q <= d;
   end

   assign WB_DAT_OUT = q.rdat;
   assign WB_ACK_OUT = q.ack;
   assign MOTOR_OPEN_OUT = q.open;
   assign MOTOR_CLOSE_OUT = q.close;

   a_manual_open: assert property (
      @(posedge SYS_CLK_IN) disable iff (SRST_IN)
      q.ovr && key_up && !key_dn |=> MOTOR_OPEN_OUT && !MOTOR_CLOSE_OUT)
      else $error("override up key did not open");
   a_override_stop: assert property (
      @(posedge SYS_CLK_IN) disable iff (SRST_IN)
      q.ovr && !key_up && !key_dn |=> !MOTOR_OPEN_OUT && !MOTOR_CLOSE_OUT)
      else $error("override without keys moved the motor");
   a_never_both: assert property (
      @(posedge SYS_CLK_IN) disable iff (SRST_IN)
      !(MOTOR_OPEN_OUT && MOTOR_CLOSE_OUT))
      else $error("open and close driven together");
   a_wiper_close: assert property (
      @(posedge SYS_CLK_IN) disable iff (SRST_IN)
      q.fb && wiper_f && !q.ovr && q.wact == ACT_CLOSE
      |=> MOTOR_CLOSE_OUT && !MOTOR_OPEN_OUT)
      else $error("wiper fault action not driven");
   a_low_wire: assert property (
      @(posedge SYS_CLK_IN) disable iff (SRST_IN)
      q.fb && !q.ovr && !wiper_f && !q.stby && (psel != 3'h0 || !q.ierr)
      && pos_s <= 13'sh0 |=> MOTOR_OPEN_OUT)
      else $error("open not held at zero position");
   a_high_wire: assert property (
      @(posedge SYS_CLK_IN) disable iff (SRST_IN)
      q.fb && !q.ovr && !wiper_f && !q.stby && (psel != 3'h0 || !q.ierr)
      && pos_s >= 13'sh3E8 |=> MOTOR_CLOSE_OUT)
      else $error("close not held at full position");
   a_preset_nofb: assert property (
      @(posedge SYS_CLK_IN) disable iff (SRST_IN)
      !q.fb && !q.ovr && !q.stby && psel == 3'h2
      |=> MOTOR_CLOSE_OUT && !MOTOR_OPEN_OUT)
      else $error("preset two did not close");
   a_dz_range: assert property (
      @(posedge SYS_CLK_IN) disable iff (SRST_IN)
      ##1 (q.dz >= 7'h02 && q.dz <= 7'h64))
      else $error("dead zone left its range");
   a_ack_once: assert property (
      @(posedge SYS_CLK_IN) disable iff (SRST_IN)
      WB_ACK_OUT |=> !WB_ACK_OUT)
      else $error("ack held for two cycles");
endmodule

// ---- dv/soa_motor_model.sv ----
// Behavioural control motor with a feedback potentiometer and end switches.
`timescale 1ns/1ps
module soa_motor_model #(
   parameter int STEP_CYC = 4
)
(
   input wire logic clk_in,
   input wire logic open_in,
   input wire logic close_in,
   input wire logic low_open_in,
   input wire logic high_open_in,
   input wire logic wiper_open_in,
   output logic [11:0] pos_out,
   output logic wiper_open_out
);
   int pos = 0;
   int div = 0;
   logic [11:0] churn = 12'h000;
   // End switches stop travel, so the shaft never leaves 0 to 1000.
   always @(posedge clk_in)
   begin
      churn <= churn + 12'h5A5;
      div <= (div + 1) % STEP_CYC;
      if (div == 0 && open_in && !close_in && pos < 1000)
         pos <= pos + 1;
      else if (div == 0 && close_in && !open_in && pos > 0)
         pos <= pos - 1;
   end
   // A broken wiper leaves the input floating, so it reads as noise.
   always_comb
   begin
      if (wiper_open_in)
         pos_out = churn;
      else if (low_open_in)
         pos_out = 12'hFFB;
      else if (high_open_in)
         pos_out = 12'h3ED;
      else
         pos_out = pos[11:0];
   end
   assign wiper_open_out = wiper_open_in;
endmodule

// ---- dv/testbench.sv ----
// Self-checking bench for the servo output arbiter with a motor model.
`timescale 1ns/1ps
module testbench;
   localparam int PU = 2;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'hF;
   logic [31:0] wdat = 32'h0;
   logic up = 1'b0;
   logic dn = 1'b0;
   logic [2:0] psel = 3'h0;
   logic lo_open = 1'b0;
   logic hi_open = 1'b0;
   logic wp_open = 1'b0;
   logic msamp = 1'b0;
   logic pdir = 1'b0;
   wire [31:0] rdat;
   wire ack, m_open, m_close, wflag;
   wire [11:0] pos;
   int n_fail = 0;
   int n_checks = 0;
   int band_lo = -5000;
   int band_hi = 5000;
   int plen = 0;
   int d;
   int dzv[5] = '{40, 8, 4, 2, 100};
   int hyv[5] = '{10, 3, 3, 2, 25};
   logic [31:0] rq[$];
   logic [2:0] mq[$];
   logic [8:0] pq[$];
   wire in_band = $signed(pos) >= band_lo && $signed(pos) <= band_hi;

   always #25 clk = ~clk;

   soa_servo_top #(.PERIOD_CYC(200), .PULSE_UNIT_CYC(PU), .EST_UNIT_CYC(2),
      .BUMP_CYC(2)) soa_servo_top_i (.SYS_CLK_IN(clk), .SRST_IN(srst),
      .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
      .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
      .WB_ACK_OUT(ack), .KEY_UP_IN(up), .KEY_DOWN_IN(dn),
      .PRESET_SEL_IN(psel), .WIPER_OPEN_IN(wflag), .POS_IN(pos),
      .MOTOR_OPEN_OUT(m_open), .MOTOR_CLOSE_OUT(m_close));

   soa_motor_model soa_motor_model_i (.clk_in(clk), .open_in(m_open),
      .close_in(m_close), .low_open_in(lo_open), .high_open_in(hi_open),
      .wiper_open_in(wp_open), .pos_out(pos), .wiper_open_out(wflag));

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
      cmp(got, exp);
   endtask
   task automatic cmp_mot(input logic [2:0] got, input logic [2:0] exp);
      cmp(32'(got), 32'(exp));
   endtask
   task automatic cmp_pul(input logic [8:0] got, input logic [8:0] exp);
      cmp(32'(got), 32'(exp));
   endtask

   // Results are matched in arrival order; pulses only when one is noted.
   always @(posedge clk)
   begin
      if (ack === 1'b1 && we === 1'b0 && rq.size() > 0)
         cmp_rd(rdat, rq.pop_front());
      if (msamp && mq.size() > 0)
         cmp_mot({in_band, m_open, m_close}, mq.pop_front());
      if (m_open === 1'b1 || m_close === 1'b1)
      begin
         plen <= plen + 1;
         pdir <= m_open;
      end
      else if (plen > 0)
      begin
         if (pq.size() > 0)
            cmp_pul({pdir, 8'(plen)}, pq.pop_front());
         plen <= 0;
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
      int t;
      t = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= v;
      do
      begin
         @(posedge clk);
         t++;
      end
      while (ack !== 1'b1 && t < 50);
      if (t >= 50)
         n_fail++;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      wb(1'b1, a, v);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rq.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask
   task automatic chk_m(input logic [2:0] e);
      mq.push_back(e);
      msamp <= 1'b1;
      @(posedge clk);
      msamp <= 1'b0;
      @(posedge clk);
   endtask
   // Pins pass a synchroniser, so give them time before looking.
   task automatic pins(input logic u, input logic w, input logic [2:0] s);
      up <= u;
      dn <= w;
      psel <= s;
      tick(8);
   endtask
   task automatic settle;
      int q, t;
      q = 0;
      t = 0;
      while (q < 20 && t < 20000)
      begin
         @(posedge clk);
         t++;
         q = (m_open === 1'b0 && m_close === 1'b0) ? q + 1 : 0;
      end
      if (t >= 20000)
         n_fail++;
   endtask
   task automatic pulse_chk(input logic o);
      int t;
      t = 0;
      // Travel to the end stop comes first and is not a pulse.
      while (t < 20000 && (o ? m_open : m_close) === 1'b1)
      begin
         @(posedge clk);
         t++;
      end
      while (t < 20000 && (o ? m_open : m_close) !== 1'b1)
      begin
         @(posedge clk);
         t++;
      end
      while (t < 20000 && (o ? m_open : m_close) === 1'b1)
      begin
         @(posedge clk);
         t++;
      end
      if (t >= 20000)
         n_fail++;
      @(posedge clk);
      pq.push_back({o, 8'(4 * PU)});
      tick(400);
   endtask
   function automatic logic [31:0] st(input logic [2:0] s,
      input logic [1:0] co, input logic f);
      return {9'h000, 7'h05, 10'h000, f, s, co};
   endfunction
   task automatic give_verdict;
      // A noted result that never appeared is a mismatch as well.
      if (rq.size() + mq.size() + pq.size() > 0)
         n_fail++;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial
   begin
      void'($urandom(27126));
      tick(12);
      srst <= 1'b0;
      @(posedge clk);
      rd(8'h08, 32'h14);
      rd(8'h3C, 32'h0);
      wr(8'h08, 32'h1);
      wr(8'h08, 32'h65);
      rd(8'h08, 32'h14);
      wr(8'h00, 32'h1);
      foreach (dzv[i])
      begin
         wr(8'h08, 32'(dzv[i]));
         rd(8'h18, 32'(hyv[i]) << 16);
      end
      wr(8'h08, 32'h14);
      pins(1'b1, 1'b0, 3'h0);
      chk_m(3'b110);
      pins(1'b0, 1'b1, 3'h0);
      chk_m(3'b101);
      wr(8'h00, 32'h5);
      pins(1'b1, 1'b0, 3'h3);
      chk_m(3'b110);
      pins(1'b0, 1'b0, 3'h3);
      chk_m(3'b100);
      wr(8'h00, 32'h0);
      chk_m(3'b110);
      for (int s = 1; s < 8; s++)
      begin
         pins(1'b0, 1'b0, 3'(s));
         chk_m({1'b1, s == 3, s == 2});
         rd(8'h18, st(3'h2, {s == 2, s == 3}, 1'b0));
      end
      wr(8'h00, 32'h208);
      pins(1'b0, 1'b0, 3'h2);
      rd(8'h18, st(3'h2, 2'b10, 1'b0));
      pins(1'b0, 1'b0, 3'h0);
      rd(8'h18, st(3'h6, 2'b01, 1'b0));
      wr(8'h00, 32'h24C);
      rd(8'h18, st(3'h3, 2'b10, 1'b0));
      wr(8'h00, 32'h24D);
      rd(8'h18, st(3'h0, 2'b00, 1'b0));
      wr(8'h00, 32'h0);
      wr(8'h14, 32'h4);
      pulse_chk(1'b0);
      wr(8'h04, 32'h3E8);
      pulse_chk(1'b1);
      wr(8'h00, 32'h2);
      d = 100 + $urandom % 801;
      wr(8'h04, 32'(d));
      settle();
      band_lo = d - 12;
      band_hi = d + 12;
      chk_m(3'b100);
      wr(8'h0C, 32'h0320_00C8);
      wr(8'h04, 32'h384);
      settle();
      band_lo = 788;
      band_hi = 812;
      chk_m(3'b100);
      wr(8'h20, 32'h352);
      pins(1'b0, 1'b0, 3'h1);
      settle();
      band_lo = 838;
      band_hi = 862;
      chk_m(3'b100);
      pins(1'b0, 1'b0, 3'h0);
      rd(8'h18, st(3'h7, 2'b00, 1'b0) | 32'h40);
      tick(400);
      band_lo = -5000;
      band_hi = 5000;
      wr(8'h0C, 32'h03E8_0000);
      wr(8'h04, 32'h12C);
      chk_m(3'b101);
      wr(8'h04, 32'h3E8);
      hi_open <= 1'b1;
      tick(3);
      chk_m(3'b101);
      hi_open <= 1'b0;
      wr(8'h04, 32'h0);
      lo_open <= 1'b1;
      tick(3);
      chk_m(3'b110);
      lo_open <= 1'b0;
      wr(8'h00, 32'h22);
      wp_open <= 1'b1;
      tick(8);
      chk_m(3'b110);
      rd(8'h18, st(3'h1, 2'b01, 1'b1));
      wr(8'h00, 32'h12);
      chk_m(3'b101);
      wp_open <= 1'b0;
      give_verdict();
   end

   initial
   begin
      tick(90000);
      n_fail++;
      give_verdict();
   end
endmodule
